/* hdl/boot_config_pkg.sv */
// Overview of operation
// - Code 11 boots application flash; only it executes; loader hidden; app protected.
// - Code 01 boots loader; only loader executes; app hidden; app writable.
// - Code 10 boots application; both execute; loader at 0x0010_0000..0x0010_0fff.
// - Code 00 boots loader; first app page mirrors loader page; loader high too.
// - Boot mode and executable map change only on reboot.
// - Mixed modes allow remap of any executable page onto vector page anytime.
// - Active remap address is readable as status after a remap.
// - Fixed-size bit set gives 4 KB data flash at 0x0001_f000.
// - Fixed-size clear and disable set gives no data flash, all application.
// - Both clear: data flash from base field to flash end.
// - Disable bit honoured only while fixed-size bit is zero.
// - Post-reset clock field copied to clock selector after every reset.
// - Watchdog enabled at power-on when bit 31 is zero.
// - Crystal filter follows bit 28.
// - Lock bit zero blocks external reads except id and words; ISP sees all.
// - Both words loaded from flash at power-on and used as settings.
package boot_config_pkg;

  localparam logic [31:0] cfg0_addr        = 32'h0030_0000;
  localparam logic [31:0] cfg1_addr        = 32'h0030_0004;
  localparam logic [31:0] cfg_reset_value  = 32'hffff_ffff;
  localparam logic [31:0] loader_base      = 32'h0010_0000;
  localparam logic [31:0] loader_last      = 32'h0010_0fff;
  localparam logic [31:0] vector_page_last = 32'h0000_01ff;
  localparam logic [31:0] fixed_df_base    = 32'h0001_f000;
  localparam logic [31:0] flash_end_large  = 32'h0001_1000;
  localparam logic [31:0] flash_end_small  = 32'h0000_9000;
  localparam logic [31:0] locked_read_data = 32'hffff_ffff;
  localparam logic [31:0] page_mask        = 32'hffff_fe00;

  // Field positions in word zero, except df_base_msb, which is in word one
  localparam int wdt_en_pos     = 31;
  localparam int wdt_pd_pos     = 30;
  localparam int xtal_filt_pos  = 28;
  localparam int clk_src_lsb    = 24;
  localparam int boot_sel_lsb   = 6;
  localparam int fixed_df_pos   = 2;
  localparam int lock_pos       = 1;
  localparam int df_dis_pos     = 0;
  localparam int df_base_msb    = 19;

  localparam logic [1:0] boot_app_only    = 2'h3;
  localparam logic [1:0] boot_ldr_only    = 2'h1;
  localparam logic [1:0] boot_app_mixed   = 2'h2;
  localparam logic [1:0] boot_ldr_mixed   = 2'h0;
  localparam logic [2:0] clk_src_crystal  = 3'h0;
  localparam logic [2:0] clk_src_internal = 3'h7;

  typedef enum logic [1:0] {
    ld_idle,
    ld_word0,
    ld_word1,
    ld_done
  } load_state_t;

  // Settings handed to the rest of the chip
  typedef struct packed {
    logic        boot_from_loader;
    logic        app_exec;
    logic        loader_exec;
    logic        loader_high_map;
    logic        app_write_protect;
    logic        mixed_mode;
    logic        df_present;
    logic [31:0] df_base;
    logic [31:0] app_limit;
    logic [2:0]  clk_src;
    logic        clk_src_valid;
    logic        wdt_enable;
    logic        wdt_pd_clk_gated;
    logic        xtal_filter;
    logic        locked;
  } boot_settings_t;

  // Flash read request from the loader
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } flash_req_t;

endpackage : boot_config_pkg

/* hdl/config_decoder.sv */
`timescale 1ns/1ps
// Turns the two latched words into settings
module config_decoder (
  input  wire logic [31:0]                   word0,     // Latched word zero
  input  wire logic [31:0]                   word1,     // Latched word one
  input  wire logic                          large_dev, // 68 KB part when high
  output boot_config_pkg::boot_settings_t    settings   // Decoded settings
);

  logic [1:0]  bsel;
  logic        fixed_df;
  logic [31:0] fend;

  assign bsel     = word0[boot_config_pkg::boot_sel_lsb +: 2];
  assign fixed_df = word0[boot_config_pkg::fixed_df_pos];
  assign fend     = large_dev ? boot_config_pkg::flash_end_large
                              : boot_config_pkg::flash_end_small;

  // Mode decode and sizing
  always_comb begin
    settings = '0;
    settings.boot_from_loader = ~bsel[1];
    settings.mixed_mode       = ~bsel[0];
    case (bsel)
      boot_config_pkg::boot_app_only: begin
        settings.app_exec          = 1'b1;
        settings.app_write_protect = 1'b1;
      end
      boot_config_pkg::boot_ldr_only: begin
        settings.loader_exec = 1'b1;
      end
      boot_config_pkg::boot_app_mixed: begin
        settings.app_exec        = 1'b1;
        settings.loader_exec     = 1'b1;
        settings.loader_high_map = 1'b1;
      end
      default: begin
        settings.app_exec        = 1'b1;
        settings.loader_exec     = 1'b1;
        settings.loader_high_map = 1'b1;
      end
    endcase
    if (fixed_df) begin
      settings.df_present = 1'b1;
      settings.df_base    = boot_config_pkg::fixed_df_base;
      // Fixed 4 KB comes off the code area on both part sizes
      settings.app_limit  = fend - 32'h0000_1000;
    end else if (word0[boot_config_pkg::df_dis_pos]) begin
      settings.df_present = 1'b0;
      settings.df_base    = fend;
      settings.app_limit  = fend;
    end else begin
      settings.df_present = 1'b1;
      // Low nine bits forced clear; trust no misprogrammed word
      settings.df_base    = {12'h000,
        word1[boot_config_pkg::df_base_msb:9], 9'h000};
      settings.app_limit  = settings.df_base;
    end
    settings.clk_src = word0[boot_config_pkg::clk_src_lsb +: 3];
    settings.clk_src_valid =
      (settings.clk_src == boot_config_pkg::clk_src_crystal) ||
      (settings.clk_src == boot_config_pkg::clk_src_internal);
    settings.wdt_enable = ~word0[boot_config_pkg::wdt_en_pos];
    // Gating choice only matters when watchdog is on
    settings.wdt_pd_clk_gated = settings.wdt_enable &
      word0[boot_config_pkg::wdt_pd_pos];
    settings.xtal_filter = word0[boot_config_pkg::xtal_filt_pos];
    settings.locked = ~word0[boot_config_pkg::lock_pos];
  end

endmodule : config_decoder

/* hdl/fetch_map.sv */
`timescale 1ns/1ps
// Executable-range check and vector page translation
module fetch_map (
  input  wire logic [31:0]                   fetch_addr, // CPU address
  input  wire boot_config_pkg::boot_settings_t settings, // Decoded settings
  input  wire logic [31:0]                   remap_addr, // Vector target
  output logic [31:0]                        phys_addr,  // Translated address
  output logic                               fetch_ok    // Address executable
);

  logic in_vec;
  logic in_ldr;
  logic in_app;
  logic in_ldr_low;

  assign in_vec = fetch_addr <= boot_config_pkg::vector_page_last;
  // Loader-only boot sees the whole loader from address zero
  assign in_ldr_low = fetch_addr <= (boot_config_pkg::loader_last -
                                     boot_config_pkg::loader_base);
  assign in_ldr = (fetch_addr >= boot_config_pkg::loader_base) &&
                  (fetch_addr <= boot_config_pkg::loader_last);
  assign in_app = fetch_addr < settings.app_limit;

  // Vector page redirect, then range check
  always_comb begin
    phys_addr = fetch_addr;
    fetch_ok  = 1'b0;
    if (settings.mixed_mode && in_vec) begin
      phys_addr = remap_addr | {23'h000000, fetch_addr[8:0]};
      fetch_ok  = 1'b1;
    end else if (!settings.mixed_mode && settings.loader_exec &&
                 in_ldr_low) begin
      phys_addr = boot_config_pkg::loader_base | fetch_addr;
      fetch_ok  = 1'b1;
    end else if (in_ldr) begin
      fetch_ok  = settings.loader_high_map;
    end else if (in_app) begin
      fetch_ok  = settings.app_exec;
    end
  end

endmodule : fetch_map

/* hdl/boot_config_loader.sv */
`timescale 1ns/1ps
// Loads the user words after power-on and serves the map
module boot_config_loader (
  input  wire logic        clk,             // 20 MHz system clock
  input  wire logic        reset_n,         // Async reset, active low
  input  wire logic        por_n,           // Power-on reset flag, low at POR
  input  wire logic        large_dev,       // Size strap, 68 KB when high
  output logic             rd_req,          // Flash read strobe
  output logic [31:0]      rd_addr,         // Flash read address
  input  wire logic        rd_ack,          // Flash read data valid
  input  wire logic [31:0] rd_data,         // Flash read data
  output logic             load_done,       // Words loaded, settings valid
  input  wire logic        remap_cmd,       // Vector page remap strobe
  input  wire logic [31:0] isp_addr,        // Isp address register value
  output logic [31:0]      remap_status,    // Active remap address
  input  wire logic [31:0] fetch_addr,      // CPU fetch address
  output logic [31:0]      phys_addr,       // Translated fetch address
  output logic             fetch_ok,        // Fetch executable
  input  wire logic        ext_rd,          // External read is from debug
  input  wire logic [31:0] ext_addr,        // External read address
  input  wire logic [31:0] flash_data,      // Raw flash data
  input  wire logic        is_id_addr,      // Address is device identifier
  output logic [31:0]      ext_data,        // Data after lock filtering
  output logic [31:0]      cfg0_value,      // Latched word zero
  output logic [31:0]      cfg1_value,      // Latched word one
  output boot_config_pkg::boot_settings_t settings // Decoded settings
);

  boot_config_pkg::load_state_t st_reg, st_next;
  logic [31:0] w0_reg, w0_next;
  logic [31:0] w1_reg, w1_next;
  logic [31:0] rmp_reg, rmp_next;
  logic [31:0] xd_reg, xd_next;
  logic        por_seen_reg, por_seen_next;
  boot_config_pkg::boot_settings_t dec;

  config_decoder u_dec (
    .word0     (w0_reg),
    .word1     (w1_reg),
    .large_dev (large_dev),
    .settings  (dec)
  );

  fetch_map u_map (
    .fetch_addr (fetch_addr),
    .settings   (dec),
    .remap_addr (rmp_reg),
    .phys_addr  (phys_addr),
    .fetch_ok   (fetch_ok)
  );

  // Sequence: read word zero, then word one, then hold
  always_comb begin
    st_next       = st_reg;
    w0_next       = w0_reg;
    w1_next       = w1_reg;
    por_seen_next = por_seen_reg;
    rd_req        = 1'b0;
    rd_addr       = boot_config_pkg::cfg0_addr;
    case (st_reg)
      boot_config_pkg::ld_idle: begin
        por_seen_next = ~por_n;
        st_next       = boot_config_pkg::ld_word0;
      end
      boot_config_pkg::ld_word0: begin
        rd_req = 1'b1;
        if (rd_ack) begin
          w0_next = rd_data;
          st_next = boot_config_pkg::ld_word1;
        end
      end
      boot_config_pkg::ld_word1: begin
        rd_req  = 1'b1;
        rd_addr = boot_config_pkg::cfg1_addr;
        if (rd_ack) begin
          w1_next = rd_data;
          st_next = boot_config_pkg::ld_done;
        end
      end
      default: begin
        // Words stay frozen: later flash edits wait for reboot
        st_next = boot_config_pkg::ld_done;
      end
    endcase
  end

  // Vector page remap, only in mixed modes
  always_comb begin
    rmp_next = rmp_reg;
    if (st_reg == boot_config_pkg::ld_word1 && rd_ack) begin
      // Default vector source: loader first page or app first page
      rmp_next = dec.boot_from_loader ? boot_config_pkg::loader_base
                                      : 32'h0000_0000;
    end else if (load_done && remap_cmd && dec.mixed_mode) begin
      rmp_next = isp_addr & boot_config_pkg::page_mask;
    end
  end

  // Lock filter on external reads
  always_comb begin
    xd_next = flash_data;
    if (ext_rd && dec.locked && !is_id_addr &&
        ext_addr != boot_config_pkg::cfg0_addr &&
        ext_addr != boot_config_pkg::cfg1_addr) begin
      xd_next = boot_config_pkg::locked_read_data;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg       <= boot_config_pkg::ld_idle;
      w0_reg       <= boot_config_pkg::cfg_reset_value;
      w1_reg       <= boot_config_pkg::cfg_reset_value;
      rmp_reg      <= 32'h0000_0000;
      xd_reg       <= 32'h0000_0000;
      por_seen_reg <= 1'b0;
    end else begin
      st_reg       <= st_next;
      w0_reg       <= w0_next;
      w1_reg       <= w1_next;
      rmp_reg      <= rmp_next;
      xd_reg       <= xd_next;
      por_seen_reg <= por_seen_next;
    end
  end

  assign load_done    = (st_reg == boot_config_pkg::ld_done);
  assign remap_status = rmp_reg;
  assign ext_data     = xd_reg;
  assign cfg0_value   = w0_reg;
  assign cfg1_value   = w1_reg;

  // Watchdog power-on enable only counts after a power-on reset
  always_comb begin
    settings = dec;
    settings.wdt_enable = dec.wdt_enable & por_seen_reg;
    settings.wdt_pd_clk_gated = dec.wdt_pd_clk_gated & por_seen_reg;
  end

endmodule : boot_config_loader

/* testbench/boot_config_checker.sv */
`timescale 1ns/1ps
// Watches load order, remap handling, lock filter and decode
module boot_config_checker (
  input wire logic        clk,          // Clock
  input wire logic        reset_n,      // Reset
  input wire logic        rd_req,       // Read strobe
  input wire logic [31:0] rd_addr,      // Read address
  input wire logic        rd_ack,       // Read answer
  input wire logic        load_done,    // Words loaded
  input wire logic        remap_cmd,    // Remap strobe
  input wire logic [31:0] isp_addr,     // Remap target
  input wire logic [31:0] remap_status, // Active remap
  input wire logic [31:0] fetch_addr,   // Fetch address
  input wire logic [31:0] phys_addr,    // Translated
  input wire logic        ext_rd,       // Debug read
  input wire logic [31:0] ext_addr,     // Debug address
  input wire logic [31:0] flash_data,   // Raw data
  input wire logic        is_id_addr,   // Identifier
  input wire logic [31:0] ext_data,     // Filtered data
  input wire logic [31:0] cfg0_value,   // Word zero
  input wire logic [31:0] cfg1_value,   // Word one
  input wire boot_config_pkg::boot_settings_t settings // Decoded
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Load sequence, then words frozen until the next boot
  rd_order_a: assert property (rd_req && rd_ack && rd_addr == 32'h0030_0000
    |=> rd_req && rd_addr == 32'h0030_0004) else $error("word one not next");
  load_end_a: assert property (rd_req && rd_ack && rd_addr == 32'h0030_0004
    |=> load_done && !rd_req) else $error("load not done");
  word_hold_a: assert property (load_done
    |=> $stable(cfg0_value) && $stable(cfg1_value)) else $error("words moved");
  // Remap only in mixed modes, page aligned, mirrored onto page zero
  remap_take_a: assert property (remap_cmd && load_done && settings.mixed_mode
    |=> remap_status == ($past(isp_addr) & 32'hffff_fe00)) else $error("remap");
  remap_refuse_a: assert property (remap_cmd && load_done && !settings.mixed_mode
    |=> $stable(remap_status)) else $error("remap not refused");
  vec_mirror_a: assert property (load_done && settings.mixed_mode
    && fetch_addr[31:9] == 23'h0 |-> phys_addr == (remap_status | fetch_addr))
    else $error("vector page");
  // Lock filter: only identifier and words pass while locked
  lock_mask_a: assert property (ext_rd && load_done && !cfg0_value[1]
    && !is_id_addr && ext_addr != 32'h0030_0000 && ext_addr != 32'h0030_0004
    |=> ext_data == 32'hffff_ffff) else $error("lock leak");
  lock_open_a: assert property (ext_rd && load_done && cfg0_value[1]
    |=> ext_data == $past(flash_data)) else $error("unlocked read");
  // Field decode against the latched word
  clk_copy_a: assert property (load_done
    |-> settings.clk_src == cfg0_value[26:24]) else $error("clock source");
  df_fixed_a: assert property (load_done && cfg0_value[2]
    |-> settings.df_present && settings.df_base == 32'h0001_f000)
    else $error("fixed data flash");
  df_dis_a: assert property (load_done && !cfg0_value[2]
    |-> settings.df_present == !cfg0_value[0]) else $error("data flash off");
  boot_src_a: assert property (load_done
    |-> settings.boot_from_loader == !cfg0_value[7]) else $error("boot source");
  xtal_filt_a: assert property (load_done
    |-> settings.xtal_filter == cfg0_value[28]) else $error("filter");
endmodule : boot_config_checker

bind boot_config_loader boot_config_checker i_chk (
  .clk(clk), .reset_n(reset_n), .rd_req(rd_req), .rd_addr(rd_addr),
  .rd_ack(rd_ack), .load_done(load_done), .remap_cmd(remap_cmd),
  .isp_addr(isp_addr), .remap_status(remap_status), .fetch_addr(fetch_addr),
  .phys_addr(phys_addr), .ext_rd(ext_rd), .ext_addr(ext_addr),
  .flash_data(flash_data), .is_id_addr(is_id_addr), .ext_data(ext_data),
  .cfg0_value(cfg0_value), .cfg1_value(cfg1_value), .settings(settings)
);

/* testbench/flash_model.sv */
`timescale 1ns/1ps
// Flash array side: answers word reads after a chosen delay
module flash_model (
  input  wire logic        clk,     // System clock
  input  wire logic        rd_req,  // Read strobe
  input  wire logic [31:0] rd_addr, // Read address
  input  wire logic [31:0] word0,   // Stored word zero
  input  wire logic [31:0] word1,   // Stored word one
  input  wire logic [3:0]  delay,   // Answer delay
  output logic             rd_ack,  // Data valid
  output logic [31:0]      rd_data  // Read data
);
  logic [3:0] wait_cnt = 4'h0;
  initial rd_ack = 1'b0;
  initial rd_data = 32'h0;
  // Data churns outside the ack so stale values never look valid
  always @(posedge clk) begin
    rd_data <= ~rd_data;
    rd_ack <= 1'b0;
    if (!rd_req || rd_ack) wait_cnt <= 4'h0;
    else if (wait_cnt < delay) wait_cnt <= wait_cnt + 4'h1;
    else begin
      rd_ack <= 1'b1;
      rd_data <= (rd_addr == 32'h0030_0004) ? word1 : word0;
    end
  end
endmodule : flash_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
// Boots in every mode and checks the decoded map and filters
module tb_top;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        por_n = 1'b0;
  logic        large_dev = 1'b1;
  logic        remap_cmd = 1'b0;
  logic        ext_rd = 1'b0;
  logic        is_id_addr = 1'b0;
  logic [31:0] isp_addr = 32'h0;
  logic [31:0] fetch_addr = 32'h0;
  logic [31:0] ext_addr = 32'h0;
  logic [31:0] flash_data = 32'h0;
  logic [31:0] word0 = 32'h0;
  logic [31:0] word1 = 32'h0;
  logic [3:0]  delay = 4'h0;
  logic        rd_req, rd_ack, load_done, fetch_ok;
  logic [31:0] rd_addr, rd_data, remap_status, phys_addr, ext_data;
  logic [31:0] cfg0_value, cfg1_value;
  boot_config_pkg::boot_settings_t st;
  int num_errors = 0;
  int n_checks = 0;

  always #25 clk = ~clk;

  boot_config_loader i_dut (.clk(clk), .reset_n(reset_n), .por_n(por_n),
    .large_dev(large_dev), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_ack(rd_ack), .rd_data(rd_data), .load_done(load_done),
    .remap_cmd(remap_cmd), .isp_addr(isp_addr), .remap_status(remap_status),
    .fetch_addr(fetch_addr), .phys_addr(phys_addr), .fetch_ok(fetch_ok),
    .ext_rd(ext_rd), .ext_addr(ext_addr), .flash_data(flash_data),
    .is_id_addr(is_id_addr), .ext_data(ext_data), .cfg0_value(cfg0_value),
    .cfg1_value(cfg1_value), .settings(st));
  flash_model i_flash (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr),
    .word0(word0), .word1(word1), .delay(delay), .rd_ack(rd_ack),
    .rd_data(rd_data));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // Power-on reboot: reset held 8 cycles, then both words load
  task automatic boot(input logic [31:0] w0, w1, input logic [3:0] dly);
    word0 = w0;
    word1 = w1;
    delay = dly;
    @(negedge clk);
    reset_n = 1'b0;
    por_n = 1'b0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    por_n = 1'b1;
    repeat (40) if (!load_done) @(negedge clk);
    chk("load_done", load_done, 1);
    chk("word0", cfg0_value, w0);
    chk("word1", cfg1_value, w1);
  endtask : boot

  task automatic remap(input logic [31:0] a);
    @(negedge clk);
    remap_cmd = 1'b1;
    isp_addr = a;
    @(negedge clk);
    remap_cmd = 1'b0;
  endtask : remap

  // Debug-port read; filtered data lands one cycle later
  task automatic ext(input logic [31:0] a, d, input logic id,
                     input logic [31:0] exp);
    @(negedge clk);
    ext_rd = 1'b1;
    ext_addr = a;
    flash_data = d;
    is_id_addr = id;
    @(negedge clk);
    ext_rd = 1'b0;
    chk("ext_data", ext_data, exp);
  endtask : ext

  task automatic fch(input logic [31:0] a, input logic ok);
    @(negedge clk);
    fetch_addr = a;
    #1;
    chk("fetch_ok", fetch_ok, ok);
  endtask : fch

  // Mode sequence; base fields keep bits 8..0 and 31..20 clear
  initial begin
    boot(32'h5700_00c6, 32'h0000_e000, 4'h0);
    chk("loader_exec", st.loader_exec, 0);
    chk("app_wp", st.app_write_protect, 1);
    chk("app_limit", st.app_limit, 32'h0001_0000);
    chk("wdt_en", st.wdt_enable, 1);
    chk("wdt_pd", st.wdt_pd_clk_gated, 1);
    chk("clk_src", st.clk_src, 32'h7);
    fch(32'h0010_0000, 0);
    fch(32'h0000_1000, 1);
    remap(32'h0000_0400);
    chk("remap", remap_status, 32'h0);
    $display("test app_only done");
    boot(32'hc000_0080, 32'h0000_e000, 4'h3);
    chk("df_base", st.df_base, 32'h0000_e000);
    chk("df_align", st.df_base & 32'h0000_01ff, 32'h0);
    chk("app_limit", st.app_limit, 32'h0000_e000);
    chk("wdt_en", st.wdt_enable, 0);
    chk("clk_ok", st.clk_src_valid, 1);
    fch(32'h0010_0ffc, 1);
    fch(32'h0010_1000, 0);
    remap(32'h0000_0600);
    remap(32'h0010_0200);
    chk("remap", remap_status, 32'h0010_0200);
    fch(32'h0000_0004, 1);
    chk("phys", phys_addr, 32'h0010_0204);
    word0 = 32'h0;
    repeat (3) @(negedge clk);
    chk("word0_kept", cfg0_value, 32'hc000_0080);
    ext(32'h0000_1000, 32'h1234_5678, 0, 32'hffff_ffff);
    ext(32'h0030_0000, 32'hc000_0080, 0, 32'hc000_0080);
    ext(32'h0000_0000, 32'h0000_00aa, 1, 32'h0000_00aa);
    $display("test app_mixed done");
    boot(32'h7fff_ff39, 32'h0000_0000, 4'h1);
    chk("df_present", st.df_present, 0);
    chk("app_limit", st.app_limit, 32'h0001_1000);
    chk("remap", remap_status, 32'h0010_0000);
    fch(32'h0000_0000, 1);
    chk("phys", phys_addr, 32'h0010_0000);
    $display("test ldr_mixed done");
    large_dev = 1'b0;
    boot(32'hfbff_ff7f, 32'h0000_0000, 4'h0);
    chk("app_exec", st.app_exec, 0);
    chk("app_wp", st.app_write_protect, 0);
    chk("df_present", st.df_present, 1);
    chk("app_limit", st.app_limit, 32'h0000_8000);
    chk("clk_ok", st.clk_src_valid, 0);
    fch(32'h0000_1000, 0);
    fch(32'h0000_0ffc, 1);
    chk("phys", phys_addr, 32'h0010_0ffc);
    ext(32'h0000_1000, 32'h5a5a_a5a5, 0, 32'h5a5a_a5a5);
    $display("test ldr_only done");
    give_verdict();
  end

  // Hang guard, well beyond the hundred or so cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule : tb_top
